// ### hdl/lkas_pkg.sv
package lkas_pkg;
   // Clock rate
   localparam int unsigned CLK_MHZ = 250;
   // Timing figures in their own units
   localparam int unsigned KEY_FILTER_US = 40;
   localparam int unsigned LS_LIMIT_MS = 30;
   localparam int unsigned LS_RETRY_MS = 600;
   localparam int unsigned CHK_WAIT_MS = 40;
   localparam int unsigned CHK_WINDOW_MS = 1;
   localparam int unsigned HS_FILTER_US = 5;
   localparam int unsigned HS_RETRY_MS = 40;
   localparam int unsigned ALARM_HALF_S_MS = 500;
   // Cycle counts derived from the figures
   localparam int unsigned KEY_FILTER_CYC = KEY_FILTER_US * CLK_MHZ;
   localparam int unsigned LS_LIMIT_CYC = LS_LIMIT_MS * 1000 * CLK_MHZ;
   localparam int unsigned LS_RETRY_CYC = LS_RETRY_MS * 1000 * CLK_MHZ;
   localparam int unsigned CHK_WAIT_CYC = CHK_WAIT_MS * 1000 * CLK_MHZ;
   localparam int unsigned CHK_WINDOW_CYC = CHK_WINDOW_MS * 1000 * CLK_MHZ;
   localparam int unsigned HS_FILTER_CYC = HS_FILTER_US * CLK_MHZ;
   localparam int unsigned HS_RETRY_CYC = HS_RETRY_MS * 1000 * CLK_MHZ;
   localparam int unsigned ALARM_UNIT_CYC = ALARM_HALF_S_MS * 1000 * CLK_MHZ;
   // Counter width for all timers
   localparam int unsigned TMR_W = 32;
   // Alarm source bit positions
   localparam int unsigned ALM_FIELD_DEGR = 0;
   localparam int unsigned ALM_FIELD_OC = 1;
   localparam int unsigned ALM_FIELD_BAT = 2;
   localparam int unsigned ALM_BAT_OV = 3;
   localparam int unsigned ALM_BAT_UV = 4;
   localparam int unsigned ALM_SENSE_LOSS = 5;
   localparam int unsigned ALM_KEY_SWITCH_OPEN = 6;
   localparam int unsigned ALM_W = 7;
   // Key supervision states
   typedef enum logic [2:0] {
      LKAS_STANDBY = 3'b000,
      LKAS_FILTER = 3'b001,
      LKAS_SAT = 3'b010,
      LKAS_CHECK = 3'b011
   } lkas_key_e;
   // Driver protection states
   typedef enum logic [1:0] {
      LKAS_DRV_ON = 2'b00,
      LKAS_DRV_OFF = 2'b01
   } lkas_drv_e;
endpackage

// ### hdl/lkas_top.sv
// Overview of operation
// RL1 - Leave standby when key threshold exceeded
// RL2 - Low-side limit held 30 ms: driver off
// RL3 - Low-side retry after 600 ms
// RL4 - Saturate lamp pin after 40 us filter
// RL5 - Check key every 40 ms, 1 ms window
// RL6 - Key present if threshold reached in window
// RL7 - Relay over-current 5 us: driver off
// RL8 - Relay retry after 40 ms
// RL9 - Lamp on after selected alarm validation time
// RL10 - Five fixed alarms, two maskable alarms
// RL11 - Ignition plus self-start: overvoltage kills drivers
// RL12 - Pre-excitation lights the lamp
// RL13 - Self-start wake-up window lights the lamp
// RL14 - Test mode on entry pin, no overvoltage
// RL15 - Test mode skips ramp, start delay, validation
// RL16 - Thermal fault turns lamp driver off
// RL17 - Self-start when phase is only wake source
// RL18 - Lamp follows alarm; validation restarts
// RL19 - Counter timers, static validation selection
`timescale 1ns/1ns
`default_nettype none
module lkas_top #(
   parameter int unsigned KEY_FILTER_CYC = lkas_pkg::KEY_FILTER_CYC,
   parameter int unsigned LS_LIMIT_CYC = lkas_pkg::LS_LIMIT_CYC,
   parameter int unsigned LS_RETRY_CYC = lkas_pkg::LS_RETRY_CYC,
   parameter int unsigned CHK_WAIT_CYC = lkas_pkg::CHK_WAIT_CYC,
   parameter int unsigned CHK_WINDOW_CYC = lkas_pkg::CHK_WINDOW_CYC,
   parameter int unsigned HS_RETRY_CYC = lkas_pkg::HS_RETRY_CYC,
   parameter int unsigned ALARM_UNIT_CYC = lkas_pkg::ALARM_UNIT_CYC
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic key_detect_in,
   input wire logic ls_limit_in,
   input wire logic hs_overcurrent_in,
   input wire logic thermal_fault_in,
   input wire logic [6:0] alarm_src_in,
   input wire logic sense_alarm_en_in,
   input wire logic key_switch_alarm_en_in,
   input wire logic [1:0] alarm_time_sel_in,
   input wire logic key_switch_if_en_in,
   input wire logic selfstart_en_in,
   input wire logic key_switch_mode2_in,
   input wire logic key_switch_floating_in,
   input wire logic key_switch_low_in,
   input wire logic phase_below_th_in,
   input wire logic phase_below_prex_in,
   input wire logic phase_in_wake_band_in,
   input wire logic other_wake_in,
   input wire logic phase_wake_in,
   input wire logic test_entry_in,
   output logic awake_out,
   output logic lamp_sat_out,
   output logic lamp_on_out,
   output logic ls_enable_out,
   output logic hs_enable_out,
   output logic selfstart_out,
   output logic test_mode_out,
   output logic ramp_bypass_out,
   output logic start_delay_bypass_out
);
   localparam int unsigned W = lkas_pkg::TMR_W;

   // Key supervision state
   lkas_pkg::lkas_key_e key_reg, key_next;
   logic [W-1:0] key_cnt_reg, key_cnt_next;
   logic key_seen_reg, key_seen_next;
   // Driver protection, alarm validation, test and self-start state
   lkas_pkg::lkas_drv_e ls_reg, hs_reg;
   logic [W-1:0] ls_cnt_reg, hs_cnt_reg;
   logic [W-1:0] alarm_cnt_reg;
   logic alarm_valid_reg;
   logic test_reg;
   logic ss_reg;

   // Validation time chosen from the static selection
   wire [W-1:0] alarm_limit = W'(ALARM_UNIT_CYC) * W'({30'h0, alarm_time_sel_in} + 32'h1); // RL9 RL19
   // Fixed alarms always count, the two configurable ones through their enables
   wire [6:0] alarm_mask = {key_switch_alarm_en_in, sense_alarm_en_in, 5'h1f}; // RL10
   wire alarm_any = |(alarm_src_in & alarm_mask); // RL10
   wire bat_ov = alarm_src_in[lkas_pkg::ALM_BAT_OV];
   // Overvoltage cut in the ignition and self-start combination
   wire key_switch_risky = key_switch_floating_in | (key_switch_mode2_in & key_switch_low_in);
   wire ov_kill = key_switch_if_en_in & selfstart_en_in & key_switch_risky & bat_ov; // RL11
   wire preexcite = phase_below_th_in | phase_below_prex_in; // RL12
   wire wake_lamp = ss_reg & phase_in_wake_band_in; // RL13
   wire key_awake = (key_reg != lkas_pkg::LKAS_STANDBY);

   // Key supervision next state
   always_comb begin
      key_next = key_reg;
      key_cnt_next = key_cnt_reg + W'(1);
      key_seen_next = key_seen_reg;
      case (key_reg)
         lkas_pkg::LKAS_STANDBY: begin
            key_cnt_next = '0;
            if (key_detect_in) begin
               key_next = lkas_pkg::LKAS_FILTER; // RL1
            end
         end
         lkas_pkg::LKAS_FILTER: begin
            if (!key_detect_in) begin
               key_next = lkas_pkg::LKAS_STANDBY;
               key_cnt_next = '0;
            end else if (key_cnt_reg >= W'(KEY_FILTER_CYC - 1)) begin
               key_next = lkas_pkg::LKAS_SAT; // RL4
               key_cnt_next = '0;
            end
         end
         lkas_pkg::LKAS_SAT: begin
            if (key_cnt_reg >= W'(CHK_WAIT_CYC - 1)) begin
               key_next = lkas_pkg::LKAS_CHECK; // RL5
               key_cnt_next = '0;
               key_seen_next = 1'b0;
            end
         end
         lkas_pkg::LKAS_CHECK: begin
            if (key_detect_in) begin
               key_seen_next = 1'b1; // RL6
            end
            if (key_cnt_reg >= W'(CHK_WINDOW_CYC - 1)) begin
               key_cnt_next = '0;
               if (key_seen_reg | key_detect_in) begin
                  key_next = lkas_pkg::LKAS_SAT; // RL6
               end else begin
                  key_next = lkas_pkg::LKAS_STANDBY; // RL6
               end
            end
         end
         default: begin
            key_next = lkas_pkg::LKAS_STANDBY;
            key_cnt_next = '0;
         end
      endcase
   end

   // Key supervision registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         key_reg <= lkas_pkg::LKAS_STANDBY;
         key_cnt_reg <= '0;
         key_seen_reg <= 1'b0;
      end else begin
         key_reg <= key_next;
         key_cnt_reg <= key_cnt_next;
         key_seen_reg <= key_seen_next;
      end
   end

   // Low-side lamp driver limit and retry timer
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ls_reg <= lkas_pkg::LKAS_DRV_ON;
         ls_cnt_reg <= '0;
      end else if (ls_reg == lkas_pkg::LKAS_DRV_ON) begin
         if (!ls_limit_in) begin
            ls_cnt_reg <= '0;
         end else if (ls_cnt_reg >= W'(LS_LIMIT_CYC - 1)) begin
            ls_reg <= lkas_pkg::LKAS_DRV_OFF; // RL2
            ls_cnt_reg <= '0;
         end else begin
            ls_cnt_reg <= ls_cnt_reg + W'(1);
         end
      end else if (ls_cnt_reg >= W'(LS_RETRY_CYC - 1)) begin
         ls_reg <= lkas_pkg::LKAS_DRV_ON; // RL3
         ls_cnt_reg <= '0;
      end else begin
         ls_cnt_reg <= ls_cnt_reg + W'(1);
      end
   end

   // High-side relay driver filter and retry timer
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hs_reg <= lkas_pkg::LKAS_DRV_ON;
         hs_cnt_reg <= '0;
      end else if (hs_reg == lkas_pkg::LKAS_DRV_ON) begin
         if (!hs_overcurrent_in) begin
            hs_cnt_reg <= '0;
         end else if (hs_cnt_reg >= W'(lkas_pkg::HS_FILTER_CYC - 1)) begin
            hs_reg <= lkas_pkg::LKAS_DRV_OFF; // RL7
            hs_cnt_reg <= '0;
         end else begin
            hs_cnt_reg <= hs_cnt_reg + W'(1);
         end
      end else if (hs_cnt_reg >= W'(HS_RETRY_CYC - 1)) begin
         hs_reg <= lkas_pkg::LKAS_DRV_ON; // RL8
         hs_cnt_reg <= '0;
      end else begin
         hs_cnt_reg <= hs_cnt_reg + W'(1);
      end
   end

   // Alarm validation; test mode skips the delay, restarts when alarms clear
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alarm_cnt_reg <= '0;
         alarm_valid_reg <= 1'b0;
      end else if (!alarm_any) begin
         alarm_cnt_reg <= '0; // RL18
         alarm_valid_reg <= 1'b0; // RL18
      end else if (test_reg) begin
         alarm_valid_reg <= 1'b1; // RL15
      end else if (alarm_cnt_reg >= alarm_limit - W'(1)) begin
         alarm_valid_reg <= 1'b1; // RL9
      end else begin
         alarm_cnt_reg <= alarm_cnt_reg + W'(1);
      end
   end

   // Test mode latch and self-start wake path
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         test_reg <= 1'b0;
         ss_reg <= 1'b0;
      end else begin
         if (test_entry_in && !bat_ov) begin
            test_reg <= 1'b1; // RL14
         end
         if (other_wake_in || key_awake) begin
            ss_reg <= 1'b0;
         end else if (phase_wake_in) begin
            ss_reg <= 1'b1; // RL17
         end
      end
   end

   // Registered outputs
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         awake_out <= 1'b0;
         lamp_sat_out <= 1'b0;
         lamp_on_out <= 1'b0;
         ls_enable_out <= 1'b0;
         hs_enable_out <= 1'b0;
         selfstart_out <= 1'b0;
         test_mode_out <= 1'b0;
         ramp_bypass_out <= 1'b0;
         start_delay_bypass_out <= 1'b0;
      end else begin
         awake_out <= key_awake | ss_reg;
         lamp_sat_out <= (key_reg == lkas_pkg::LKAS_SAT); // RL4
         lamp_on_out <= (alarm_valid_reg | preexcite | wake_lamp) // RL12 RL13
            & !thermal_fault_in & !ov_kill; // RL16 RL11
         ls_enable_out <= (ls_reg == lkas_pkg::LKAS_DRV_ON) & !thermal_fault_in // RL2 RL16
            & !ov_kill; // RL11
         hs_enable_out <= (hs_reg == lkas_pkg::LKAS_DRV_ON) & !ov_kill; // RL7 RL11
         selfstart_out <= ss_reg;
         test_mode_out <= test_reg;
         ramp_bypass_out <= test_reg; // RL15
         start_delay_bypass_out <= test_reg; // RL15
      end
   end

   // Assertions
   chk_ls_limit_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL2
      (ls_reg == lkas_pkg::LKAS_DRV_ON && ls_limit_in && ls_cnt_reg == W'(LS_LIMIT_CYC - 1))
      |=> ls_reg == lkas_pkg::LKAS_DRV_OFF)
      else $error("low-side driver not switched off at limit time");
   chk_ls_retry_time: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL3
      (ls_reg == lkas_pkg::LKAS_DRV_OFF && ls_cnt_reg < W'(LS_RETRY_CYC - 1))
      |=> ls_reg == lkas_pkg::LKAS_DRV_OFF)
      else $error("low-side driver retried early");
   chk_key_standby_exit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL1
      (key_reg == lkas_pkg::LKAS_STANDBY && key_detect_in) |=> key_reg == lkas_pkg::LKAS_FILTER)
      else $error("key detect did not leave standby");
   chk_sat_follows_state: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL4
      $rose(key_reg == lkas_pkg::LKAS_SAT) |=> lamp_sat_out)
      else $error("lamp not saturated after filter");
   chk_window_bounded: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL5
      key_reg == lkas_pkg::LKAS_CHECK |-> key_cnt_reg < W'(CHK_WINDOW_CYC))
      else $error("check window too long");
   chk_key_lost_standby: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL6
      (key_reg == lkas_pkg::LKAS_CHECK && key_cnt_reg == W'(CHK_WINDOW_CYC - 1)
       && !key_seen_reg && !key_detect_in) |=> key_reg == lkas_pkg::LKAS_STANDBY)
      else $error("removed key not detected");
   chk_hs_off_filter: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL7
      (hs_reg == lkas_pkg::LKAS_DRV_ON && hs_overcurrent_in
       && hs_cnt_reg == W'(lkas_pkg::HS_FILTER_CYC - 1)) |=> ##1 !hs_enable_out)
      else $error("relay driver not switched off");
   chk_thermal_lamp_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL16
      thermal_fault_in |=> !lamp_on_out && !ls_enable_out)
      else $error("lamp on during thermal fault");
   chk_ov_kill_drivers: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL11
      ov_kill |=> !hs_enable_out && !lamp_on_out && !ls_enable_out)
      else $error("drivers on during overvoltage cut");
   chk_alarm_clear_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL18
      !alarm_any |=> !alarm_valid_reg && alarm_cnt_reg == '0)
      else $error("validation not restarted");
   // Timer holds and expiries of both drivers and of the key supervision
   chk_ls_retry_on: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL3
      (ls_reg == lkas_pkg::LKAS_DRV_OFF && ls_cnt_reg == W'(LS_RETRY_CYC - 1))
      |=> ls_reg == lkas_pkg::LKAS_DRV_ON)
      else $error("low-side driver not retried");
   chk_key_filter_time: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL4
      (key_reg == lkas_pkg::LKAS_FILTER && key_cnt_reg < W'(KEY_FILTER_CYC - 1))
      |=> key_reg != lkas_pkg::LKAS_SAT)
      else $error("lamp saturated before filter time");
   chk_sat_wait_time: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL5
      (key_reg == lkas_pkg::LKAS_SAT && key_cnt_reg < W'(CHK_WAIT_CYC - 1))
      |=> key_reg == lkas_pkg::LKAS_SAT)
      else $error("key check started early");
   chk_hs_filter_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL7
      (hs_reg == lkas_pkg::LKAS_DRV_ON && hs_cnt_reg < W'(lkas_pkg::HS_FILTER_CYC - 1))
      |=> hs_reg == lkas_pkg::LKAS_DRV_ON)
      else $error("relay driver cut before filter time");
   chk_hs_retry_early: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL8
      (hs_reg == lkas_pkg::LKAS_DRV_OFF && hs_cnt_reg < W'(HS_RETRY_CYC - 1))
      |=> hs_reg == lkas_pkg::LKAS_DRV_OFF)
      else $error("relay driver retried early");
   chk_hs_retry_on: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL8
      (hs_reg == lkas_pkg::LKAS_DRV_OFF && hs_cnt_reg == W'(HS_RETRY_CYC - 1))
      |=> hs_reg == lkas_pkg::LKAS_DRV_ON)
      else $error("relay driver not retried");
   // Alarm validation, masking and test mode
   chk_alarm_wait_time: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL9
      (alarm_any && !test_reg && !alarm_valid_reg && alarm_cnt_reg < alarm_limit - W'(1))
      |=> !alarm_valid_reg)
      else $error("alarm validated early");
   chk_mask_blocks_alarm: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL10
      (alarm_src_in[4:0] == 5'h00 && !(alarm_src_in[5] && sense_alarm_en_in)
       && !(alarm_src_in[6] && key_switch_alarm_en_in)) |=> !alarm_valid_reg)
      else $error("masked alarm validated");
   chk_test_entry_taken: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL14
      (test_entry_in && !alarm_src_in[lkas_pkg::ALM_BAT_OV]) |=> test_reg)
      else $error("test mode not entered");
   chk_test_ov_refused: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL14
      (!test_reg && alarm_src_in[lkas_pkg::ALM_BAT_OV]) |=> !test_reg)
      else $error("test mode entered in overvoltage");
   chk_test_skips_delay: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL15
      (alarm_any && test_reg) |=> alarm_valid_reg)
      else $error("validation delay kept in test mode");
   chk_bypass_follows_test: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL15
      test_reg |=> ramp_bypass_out && start_delay_bypass_out)
      else $error("bypass outputs missing in test mode");
   // Direct lamp paths and the self-start wake source
   chk_preexcite_lamp: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL12
      (preexcite && !thermal_fault_in && !ov_kill) |=> lamp_on_out)
      else $error("lamp dark in pre-excitation");
   chk_wake_band_lamp: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL13
      (ss_reg && phase_in_wake_band_in && !thermal_fault_in && !ov_kill) |=> lamp_on_out)
      else $error("lamp dark in wake-up band");
   chk_ss_phase_only: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RL17
      (other_wake_in || key_awake) |=> !ss_reg)
      else $error("self-start kept with another wake source");
endmodule
`default_nettype wire

// ### tb/lkas_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Key switch, warning lamp and relay as seen from the lamp pin
module lkas_partner (
   input wire logic key_closed_in,
   input wire logic lamp_short_in,
   input wire logic relay_short_in,
   input wire logic lamp_sat_in,
   input wire logic ls_enable_in,
   input wire logic hs_enable_in,
   output logic key_detect_out,
   output logic ls_limit_out,
   output logic hs_overcurrent_out
);
   // A saturated pin hides the key; the pull-down holds an open key low
   assign key_detect_out = key_closed_in & ~lamp_sat_in;
   // A shorted load only draws current while its driver is on
   assign ls_limit_out = lamp_short_in & ls_enable_in;
   assign hs_overcurrent_out = relay_short_in & hs_enable_in;
endmodule
`default_nettype wire

// ### tb/test_lamp_key_alarm_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module test_lamp_key_alarm_supervisor;
   // Shortened timer counts, the full package relay filter count HF, and output bit positions
   localparam int KF = 10, LL = 50, LR = 100, CW = 40, CN = 8, HR = 30, AU = 20, HF = 1250;
   localparam int AW = 8, SA = 7, LA = 6, LE = 5, HE = 4, SS = 3, TM = 2;
   logic clk = 1'b0, rst_n = 1'b0, key = 1'b0, lsh = 1'b0, rsh = 1'b0, therm = 1'b0;
   logic [6:0] alm = 7'h00;
   logic [1:0] sel = 2'h0;
   logic sen = 1'b0, ien = 1'b0, ignif = 1'b0, ssen = 1'b0, m2 = 1'b0, flo = 1'b0;
   logic low = 1'b0, pth = 1'b0, ppx = 1'b0, pwb = 1'b0, oth = 1'b0, pw = 1'b0, te = 1'b0;
   logic kd, lsl, hso, awake, sat, lamp, lse, hse, ss, tm, rb, sdb;
   logic [8:0] outs;
   int err_total = 0, n_tests = 0, cyc, b;
   assign outs = {awake, sat, lamp, lse, hse, ss, tm, rb, sdb};
   // Clock at 250 MHz
   initial begin
      forever #2 clk = ~clk;
   end
   lkas_top #(.KEY_FILTER_CYC(KF), .LS_LIMIT_CYC(LL), .LS_RETRY_CYC(LR), .CHK_WAIT_CYC(CW),
      .CHK_WINDOW_CYC(CN), .HS_RETRY_CYC(HR), .ALARM_UNIT_CYC(AU)) i_dut (
      .sys_clk_in(clk), .rst_n_in(rst_n), .key_detect_in(kd), .ls_limit_in(lsl),
      .hs_overcurrent_in(hso), .thermal_fault_in(therm), .alarm_src_in(alm),
      .sense_alarm_en_in(sen), .key_switch_alarm_en_in(ien), .alarm_time_sel_in(sel),
      .key_switch_if_en_in(ignif), .selfstart_en_in(ssen), .key_switch_mode2_in(m2),
      .key_switch_floating_in(flo), .key_switch_low_in(low), .phase_below_th_in(pth),
      .phase_below_prex_in(ppx),
      .phase_in_wake_band_in(pwb), .other_wake_in(oth), .phase_wake_in(pw),
      .test_entry_in(te), .awake_out(awake), .lamp_sat_out(sat), .lamp_on_out(lamp),
      .ls_enable_out(lse), .hs_enable_out(hse), .selfstart_out(ss), .test_mode_out(tm),
      .ramp_bypass_out(rb), .start_delay_bypass_out(sdb));
   lkas_partner i_far (.key_closed_in(key), .lamp_short_in(lsh), .relay_short_in(rsh),
      .lamp_sat_in(sat), .ls_enable_in(lse), .hs_enable_in(hse), .key_detect_out(kd),
      .ls_limit_out(lsl), .hs_overcurrent_out(hso));
   // Level comparison
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // Cycles until an output takes a level; lo below zero means it must not within hi
   task automatic lat(input string nm, input int bi, input logic v, input int lo, input int hi);
      cyc = 0;
      while (outs[bi] !== v && cyc <= hi) begin
         @(negedge clk);
         cyc++;
      end
      n_tests++;
      if (lo < 0 ? cyc <= hi : (cyc < lo || cyc > hi)) begin
         err_total++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, cyc);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog well past the expected run length
   initial begin
      #(40000 * 4);
      err_total++;
      wrap_up();
   end
   // Main sequence, inputs changed at falling edges
   initial begin
      void'($urandom(88));
      step(12);
      chk("outputs in reset", 9'h000, outs);
      rst_n = 1'b1;
      step(3);
      chk("drivers after reset", 2'h3, {lse, hse});
      key = 1'b1;
      lat("wake", AW, 1'b1, 1, 4);
      lat("saturate", SA, 1'b1, KF - 1, KF + 3);
      lat("check window", SA, 1'b0, CW - 2, CW + 3);
      lat("key seen", SA, 1'b1, 1, CN + 3);
      key = 1'b0;
      lat("key lost", AW, 1'b0, CW + CN - 2, CW + CN + 5);
      // Lamp driver limit and retry
      lsh = 1'b1;
      lat("lamp limit", LE, 1'b0, LL - 1, LL + 4);
      lat("lamp retry", LE, 1'b1, LR - 1, LR + 4);
      lsh = 1'b0;
      // Relay burst shorter than the filter, then a lasting fault
      rsh = 1'b1;
      lat("relay burst", HE, 1'b0, -1, HF - 50);
      rsh = 1'b0;
      step(3);
      rsh = 1'b1;
      lat("relay cut", HE, 1'b0, HF - 1, HF + 4);
      rsh = 1'b0;
      lat("relay retry", HE, 1'b1, HR - 1, HR + 4);
      // Every validation option with a random fixed source
      for (int i = 0; i < 4; i++) begin
         sel = 2'(i);
         b = $urandom % 5;
         alm[b] = 1'b1;
         lat("alarm lamp", LA, 1'b1, (i + 1) * AU - 1, (i + 1) * AU + 4);
         alm = 7'h00;
         lat("alarm clear", LA, 1'b0, 1, 4);
      end
      alm = 7'h60;
      lat("masked", LA, 1'b1, -1, 4 * AU + 8);
      alm = 7'h00;
      {sen, ien, sel} = 4'hc;
      // Enabled maskable sources, interrupted once to restart validation
      for (int j = 5; j < 7; j++) begin
         alm[j] = 1'b1;
         step(AU / 2);
         alm = 7'h00;
         step(2);
         alm[j] = 1'b1;
         lat("restart", LA, 1'b1, AU - 1, AU + 4);
         alm = 7'h00;
         step(4);
      end
      // Wake band stays dark until phase alone has woken the device
      pwb = 1'b1;
      lat("band without self-start", LA, 1'b1, -1, 6);
      pwb = 1'b0;
      pw = 1'b1;
      lat("self-start", SS, 1'b1, 1, 4);
      // Direct lamp paths, each overridden by a thermal fault
      for (int k = 0; k < 3; k++) begin
         {pth, ppx, pwb} = 3'(1 << k);
         lat("direct lamp", LA, 1'b1, 1, 4);
         therm = 1'b1;
         lat("thermal", LA, 1'b0, 1, 4);
         chk("thermal lamp driver", 1'b0, lse);
         {pth, ppx, pwb, therm} = 4'h0;
         step(4);
      end
      oth = 1'b1;
      lat("other source", SS, 1'b0, 1, 4);
      {pw, oth} = 2'h0;
      // Over-voltage with floating, then low ignition in the second mode
      {ignif, ssen, flo} = 3'h7;
      alm[3] = 1'b1;
      lat("ov cut", HE, 1'b0, 1, 4);
      chk("ov lamp driver", 1'b0, lse);
      {m2, flo, low} = 3'h5;
      lat("ov lamp", LA, 1'b1, -1, AU + 8);
      chk("ov mode two", 2'h0, {lse, hse});
      m2 = 1'b0;
      lat("ov mode one low", HE, 1'b1, 1, 4);
      {ignif, ssen, m2, low} = 4'h0;
      // Test entry refused in over-voltage, then taken
      te = 1'b1;
      step(6);
      chk("test refused", 1'b0, tm);
      alm = 7'h00;
      lat("test entry", TM, 1'b1, 1, 4);
      chk("bypass", 2'h3, {rb, sdb});
      te = 1'b0;
      alm[0] = 1'b1;
      lat("fast alarm", LA, 1'b1, 1, 4);
      chk("test sticky", 1'b1, tm);
      // Second reset in mid-run clears the sticky test mode
      rst_n = 1'b0;
      step(2);
      chk("outputs in second reset", 9'h000, outs);
      rst_n = 1'b1;
      step(3);
      chk("test cleared by reset", 3'h0, {tm, rb, sdb});
      wrap_up();
   end
endmodule
`default_nettype wire
